// ==== core/cupwm_pkg.sv ====
/*
  Package for the pulse-width unit: register offsets, field positions,
  reset values and the APB register carrier.
  Assumes a 32-bit APB with word-aligned registers.
*/
package cupwm_pkg;

  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_DUTY_BYTE = 8'h04;
  localparam logic [7:0] OFF_ACTIVE_DUTY = 8'h08;
  localparam logic [7:0] OFF_PERIOD = 8'h0C;
  localparam logic [7:0] OFF_TIMER_CTRL = 8'h10;
  localparam logic [7:0] OFF_TIMER = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // Unit control field positions
  localparam int CTL_DLOW_HI = 5;
  localparam int CTL_DLOW_LO = 4;
  localparam int CTL_MODE_HI = 3;
  localparam int CTL_MODE_LO = 0;
  localparam logic [7:0] CTL_IMPL_MASK = 8'h3F;
  localparam logic [3:0] MODE_PWM_MASK = 4'hC;

  // Timer control field positions
  localparam int TC_OUTPS_HI = 6;
  localparam int TC_OUTPS_LO = 3;
  localparam int TC_ON = 2;
  localparam int TC_CKPS_HI = 1;
  localparam int TC_CKPS_LO = 0;
  localparam logic [7:0] TC_IMPL_MASK = 8'h7F;

  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] TIMER_CTRL_RST = 8'h00;

  // Four oscillator phases per timer count
  localparam int PHASES_PER_COUNT = 4;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] duty_byte;
    logic [7:0] period;
    logic [7:0] timer_ctrl;
  } cupwm_regs_s;

endpackage

// ==== core/cupwm_top.sv ====
/*
  Pulse-width modulation unit with APB register access and its own period timer.
  Assumes pclk is the oscillator clock (one phase per pclk) and that a
  port-level direction bit outside gates the pin.
*/
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - Pin carries pulse-width waveform, 10-bit resolution
// - Zero control write clears unit output latch
// - Period register sets pulse period
// - Timer clears on increment after period match
// - Pin set at period match unless duty zero
// - Duty byte and low bits latched at match
// - Postscaler does not affect pulse period
// - Duty is byte then control bits 5:4
// - Duty writes anytime, effective next period
// - Active duty read-only in pulse mode
// - Active duty plus 2-bit latch double-buffer
// - Pin clears when duty equals extended timer
// - Duty beyond period keeps pin high
// - High time is duty times osc times prescale
// - Prescale factors one, four, sixteen
// - Unimplemented bits read zero
module cupwm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pulse_output_pin,
  output logic timer_event
);

  cupwm_pkg::cupwm_regs_s regs_q;
  logic [7:0] active_duty_q;
  logic [1:0] duty_low_latch_q;
  logic [7:0] period_timer_q;
  logic [3:0] prescale_q;
  logic [1:0] phase_q;
  logic [3:0] postscale_q;
  logic out_q;
  logic timer_event_q;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic pwm_mode;
  logic timer_on;
  logic count_tick;
  logic period_match;
  logic incr_match;
  logic [9:0] duty_next;
  logic [9:0] time_base;
  logic [3:0] prescale_max;
  logic [1:0] sub_bits;
  logic base_step;
  logic [9:0] duty_active;
  logic [9:0] duty_last_step;
  logic [9:0] hi_steps_q;
  logic steps_clean_q;
  logic [1:0] ckps_q;

  // ==========================================================
  // APB slave
  // ==========================================================
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == cupwm_pkg::OFF_CONTROL) || (a == cupwm_pkg::OFF_DUTY_BYTE) ||
             (a == cupwm_pkg::OFF_ACTIVE_DUTY) || (a == cupwm_pkg::OFF_PERIOD) ||
             (a == cupwm_pkg::OFF_TIMER_CTRL) || (a == cupwm_pkg::OFF_TIMER) ||
             (a == cupwm_pkg::OFF_STATUS);
  endfunction

  assign addr_ok = mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok && pstrb[0];
  assign rd_en = psel && penable && !pwrite;

  assign pwm_mode = (regs_q.control[cupwm_pkg::CTL_MODE_HI:cupwm_pkg::CTL_MODE_LO] &
                     cupwm_pkg::MODE_PWM_MASK) == cupwm_pkg::MODE_PWM_MASK;
  assign timer_on = regs_q.timer_ctrl[cupwm_pkg::TC_ON];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regs_q.control <= cupwm_pkg::CONTROL_RST;
      regs_q.duty_byte <= cupwm_pkg::DUTY_RST;
      regs_q.period <= cupwm_pkg::PERIOD_RST;
      regs_q.timer_ctrl <= cupwm_pkg::TIMER_CTRL_RST;
    end else if (wr_en) begin
      unique case (paddr)
        cupwm_pkg::OFF_CONTROL: regs_q.control <= pwdata[7:0] & cupwm_pkg::CTL_IMPL_MASK;
        cupwm_pkg::OFF_DUTY_BYTE: regs_q.duty_byte <= pwdata[7:0];
        cupwm_pkg::OFF_PERIOD: regs_q.period <= pwdata[7:0];
        cupwm_pkg::OFF_TIMER_CTRL: regs_q.timer_ctrl <= pwdata[7:0] & cupwm_pkg::TC_IMPL_MASK;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        cupwm_pkg::OFF_CONTROL: prdata = {24'h00_0000, regs_q.control};
        cupwm_pkg::OFF_DUTY_BYTE: prdata = {24'h00_0000, regs_q.duty_byte};
        cupwm_pkg::OFF_ACTIVE_DUTY: prdata = {24'h00_0000, active_duty_q};
        cupwm_pkg::OFF_PERIOD: prdata = {24'h00_0000, regs_q.period};
        cupwm_pkg::OFF_TIMER_CTRL: prdata = {24'h00_0000, regs_q.timer_ctrl};
        cupwm_pkg::OFF_TIMER: prdata = {24'h00_0000, period_timer_q};
        cupwm_pkg::OFF_STATUS: prdata = {28'h000_0000, duty_low_latch_q, pwm_mode, out_q};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Prescaler and period timer
  // ==========================================================
  // Count width covers factor 16; factor 1 leaves sub-cycle phase bits.
  always_comb begin
    unique case (regs_q.timer_ctrl[cupwm_pkg::TC_CKPS_HI:cupwm_pkg::TC_CKPS_LO])
      2'b00: prescale_max = 4'h0;
      2'b01: prescale_max = 4'h3;
      default: prescale_max = 4'hF;
    endcase
  end

  // One timer count = 4 phases times prescale factor
  assign count_tick = timer_on && (phase_q == 2'(cupwm_pkg::PHASES_PER_COUNT - 1)) &&
                      (prescale_q == prescale_max);
  assign period_match = period_timer_q == regs_q.period;
  assign incr_match = count_tick && period_match;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= 2'h0;
    end else if (timer_on) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_q <= 4'h0;
    end else if (!timer_on) begin
      prescale_q <= 4'h0;
    end else if (phase_q == 2'(cupwm_pkg::PHASES_PER_COUNT - 1)) begin
      prescale_q <= (prescale_q == prescale_max) ? 4'h0 : prescale_q + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_timer_q <= 8'h00;
    end else if (incr_match) begin
      period_timer_q <= 8'h00;
    end else if (count_tick) begin
      period_timer_q <= period_timer_q + 8'h01;
    end
  end

  // Postscaler only paces the timer event, never the pulse period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      postscale_q <= 4'h0;
      timer_event_q <= 1'b0;
    end else begin
      timer_event_q <= 1'b0;
      if (incr_match) begin
        if (postscale_q == regs_q.timer_ctrl[cupwm_pkg::TC_OUTPS_HI:cupwm_pkg::TC_OUTPS_LO]) begin
          postscale_q <= 4'h0;
          timer_event_q <= 1'b1;
        end else begin
          postscale_q <= postscale_q + 4'h1;
        end
      end
    end
  end
  assign timer_event = timer_event_q;

  // ==========================================================
  // Duty buffering and output
  // ==========================================================
  assign duty_next = {regs_q.duty_byte,
                      regs_q.control[cupwm_pkg::CTL_DLOW_HI:cupwm_pkg::CTL_DLOW_LO]};

  // Active duty is written only here, so bus writes cannot reach it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_duty_q <= cupwm_pkg::DUTY_RST;
      duty_low_latch_q <= 2'h0;
    end else if (incr_match) begin
      active_duty_q <= duty_next[9:2];
      duty_low_latch_q <= duty_next[1:0];
    end
  end

  // Low bits: phase at prescale 1, else two prescaler bits
  assign sub_bits = (prescale_max == 4'h0) ? phase_q :
                    (prescale_max == 4'h3) ? prescale_q[1:0] : prescale_q[3:2];
  assign time_base = {period_timer_q, sub_bits};

  // Time base advances once per prescale unit; dropping on the step into the
  // duty value gives exactly duty units of high time, not one unit more
  assign base_step = timer_on && ((prescale_max == 4'h0) ||
                     ((phase_q == 2'h3) && ((prescale_max == 4'h3) || (prescale_q[1:0] == 2'h3))));
  assign duty_active = {active_duty_q, duty_low_latch_q};
  assign duty_last_step = duty_active - 10'h001;

  // High time = duty phases times prescale; duty past period never matches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    end else if (regs_q.control == cupwm_pkg::CONTROL_RST) begin
      out_q <= 1'b0;
    end else if (!pwm_mode) begin
      out_q <= out_q;
    end else if (incr_match) begin
      out_q <= (duty_next != 10'h000);
    end else if (base_step && time_base == duty_last_step) begin
      out_q <= 1'b0;
    end
  end
  assign pulse_output_pin = out_q;

  // ==========================================================
  // Check helpers
  // ==========================================================
  // Counts time-base steps while high; a prescale change spoils the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ckps_q <= 2'h0;
      steps_clean_q <= 1'b0;
      hi_steps_q <= 10'h000;
    end else begin
      ckps_q <= regs_q.timer_ctrl[cupwm_pkg::TC_CKPS_HI:cupwm_pkg::TC_CKPS_LO];
      if (ckps_q != regs_q.timer_ctrl[cupwm_pkg::TC_CKPS_HI:cupwm_pkg::TC_CKPS_LO]) begin
        steps_clean_q <= 1'b0;
      end else if (incr_match) begin
        steps_clean_q <= 1'b1;
      end
      if (incr_match) begin
        hi_steps_q <= 10'h000;
      end else if (base_step && out_q) begin
        hi_steps_q <= hi_steps_q + 10'h001;
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  timer_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    incr_match |=> period_timer_q == 8'h00)
    else $error("timer not cleared after period match");

  pin_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (incr_match && pwm_mode && duty_next != 10'h000) |=> out_q)
    else $error("pin not set at period match");

  pin_zero_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
    (incr_match && pwm_mode && duty_next == 10'h000) |=> !out_q)
    else $error("pin set with zero duty");

  duty_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    incr_match |=> {active_duty_q, duty_low_latch_q} == $past(duty_next))
    else $error("duty not latched at match");

  duty_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !incr_match |=> $stable(active_duty_q) && $stable(duty_low_latch_q))
    else $error("active duty changed mid period");

  control_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (regs_q.control == 8'h00) |=> !out_q)
    else $error("output not low after control cleared");

  pin_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pwm_mode && base_step && !incr_match && regs_q.control != 8'h00 &&
     time_base == duty_last_step) |=> !out_q)
    else $error("pin not cleared on duty match");

  high_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(out_q) && $past(regs_q.control) != 8'h00 && steps_clean_q) |-> hi_steps_q == duty_active)
    else $error("high time differs from duty");

  stay_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pwm_mode && out_q && !incr_match && regs_q.control != 8'h00 &&
     period_timer_q <= regs_q.period && duty_last_step > {regs_q.period, 2'h3}) |=> out_q)
    else $error("pin cleared with duty beyond period");

  zero_duty_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pwm_mode && duty_active == 10'h000 && !incr_match && !out_q) |=> !out_q)
    else $error("pin rose with zero duty");

  mode_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!pwm_mode && regs_q.control != 8'h00) |=> out_q == $past(out_q))
    else $error("pin moved outside pulse mode");

  active_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == cupwm_pkg::OFF_ACTIVE_DUTY && !incr_match) |=> $stable(active_duty_q))
    else $error("active duty written by bus");

  period_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == cupwm_pkg::OFF_PERIOD) |=> regs_q.period == $past(pwdata[7:0]))
    else $error("period write lost");

  duty_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == cupwm_pkg::OFF_DUTY_BYTE) |=> regs_q.duty_byte == $past(pwdata[7:0]))
    else $error("duty byte write lost");

  control_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == cupwm_pkg::OFF_CONTROL) |=>
    regs_q.control == ($past(pwdata[7:0]) & cupwm_pkg::CTL_IMPL_MASK))
    else $error("control write not masked");

  status_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == cupwm_pkg::OFF_STATUS) |-> prdata[31:4] == 28'h000_0000)
    else $error("status upper bits not zero");

  prdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_en |-> prdata == 32'h0000_0000)
    else $error("read data not idle");

  slverr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !addr_ok) |-> pslverr)
    else $error("unmapped access not flagged");

  timer_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (count_tick && !period_match) |=> period_timer_q == $past(period_timer_q) + 8'h01)
    else $error("timer did not step");

  tick_apart_a: assert property (@(posedge pclk) disable iff (!presetn)
    count_tick |=> !count_tick)
    else $error("timer ticks too close");

  timer_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !timer_on |=> $stable(period_timer_q))
    else $error("timer moved while off");

  prescale_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !timer_on |=> prescale_q == 4'h0)
    else $error("prescaler not cleared while off");

  event_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_event_q |-> $past(incr_match))
    else $error("timer event without period match");

  event_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_event_q |=> !timer_event_q)
    else $error("timer event longer than one cycle");

  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    regs_q.control[7:6] == 2'b00 && regs_q.timer_ctrl[7] == 1'b0)
    else $error("unimplemented bits not zero");

  period_cover_c: cover property (@(posedge pclk) disable iff (!presetn) incr_match && pwm_mode);
  fall_cover_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(out_q) && pwm_mode);
  event_cover_c: cover property (@(posedge pclk) disable iff (!presetn) timer_event_q);
  zero_cover_c: cover property (@(posedge pclk) disable iff (!presetn) incr_match && pwm_mode && duty_next == 10'h000);
  high_cover_c: cover property (@(posedge pclk) disable iff (!presetn) incr_match && pwm_mode && out_q);

endmodule // cupwm_top

// ==== verif/cupwm_meter.sv ====
/*
  Far-side model: a circuit that watches the pulse pin and measures it.
  Assumes the pin is sampled on pclk and that the bench reads its results.
*/
`timescale 1ns/1ns
// ==========================
// Pulse meter
module cupwm_meter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic [15:0] hi_len,
  output logic [15:0] per_len,
  output logic [15:0] n_rise
);
  logic pin_q;
  logic [15:0] hi_c;
  logic [15:0] per_c;
  // Edge to edge counts, so pin latency does not matter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pin_q, hi_c, per_c, hi_len, per_len, n_rise} <= '0;
    end else begin
      pin_q <= pin;
      per_c <= (pin && !pin_q) ? 16'h0001 : per_c + 16'h0001;
      hi_c <= (pin && !pin_q) ? 16'h0001 : hi_c + 16'h0001;
      if (pin && !pin_q) begin
        per_len <= per_c;
        n_rise <= n_rise + 16'h0001;
      end
      if (!pin && pin_q) begin
        hi_len <= hi_c;
      end
    end
  end
endmodule // cupwm_meter

// ==== verif/tb.sv ====
/*
  Self-checking bench for the pulse-width unit, driven over APB.
  Assumes zero-or-more wait APB slave and the pulse meter model.
*/
`timescale 1ns/1ns
// ==========================
// Bench top
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin;
  logic [15:0] hi_len;
  logic [15:0] per_len;
  logic [15:0] n_rise;
  logic [15:0] n_hold;
  logic tev;
  int n_ev = 0;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 pclk = ~pclk;
  cupwm_top cupwm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_output_pin(pin), .timer_event(tev));
  cupwm_meter cupwm_meter_inst (.pclk(pclk), .presetn(presetn), .pin(pin), .hi_len(hi_len),
    .per_len(per_len), .n_rise(n_rise));
  task automatic complete_run();
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Called just after an edge; lets one idle edge pass after the access before returning
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [31:0] exp,
    input logic exp_err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk({31'h0, pslverr}, {31'h0, exp_err});
    if (!w) chk(prdata, exp);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, {24'h0, exp}, 1'b0);
  endtask
  task automatic wait_rise(input int n);
    logic [15:0] n0;
    n0 = n_rise;
    while (int'(n_rise - n0) < n) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (tev === 1'b1) n_ev <= n_ev + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ==========================
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(cupwm_pkg::OFF_CONTROL, cupwm_pkg::CONTROL_RST);
    rd(cupwm_pkg::OFF_DUTY_BYTE, cupwm_pkg::DUTY_RST);
    rd(cupwm_pkg::OFF_PERIOD, cupwm_pkg::PERIOD_RST);
    rd(cupwm_pkg::OFF_TIMER_CTRL, cupwm_pkg::TIMER_CTRL_RST);
    rd(cupwm_pkg::OFF_TIMER, 8'h00);
    apb(1'b0, 8'h1C, 8'h00, 32'h0, 1'b1);
    wr(cupwm_pkg::OFF_CONTROL, 8'hFF);
    rd(cupwm_pkg::OFF_CONTROL, 8'h3F);
    wr(cupwm_pkg::OFF_CONTROL, 8'h00);
    wr(cupwm_pkg::OFF_TIMER_CTRL, 8'h80);
    rd(cupwm_pkg::OFF_TIMER_CTRL, 8'h00);
    // Setup order period, duty, timer, mode; duty = {02,01} = 9
    wr(cupwm_pkg::OFF_PERIOD, 8'h07);
    wr(cupwm_pkg::OFF_DUTY_BYTE, 8'h02);
    wr(cupwm_pkg::OFF_CONTROL, 8'h10);
    for (int k = 0; k < 3; k++) begin
      // Last pass also sets full postscale, which must not move the period
      wr(cupwm_pkg::OFF_TIMER_CTRL, {1'b0, (k == 2) ? 4'hF : 4'h0, 1'b1, 2'(k)});
      if (k == 0) wr(cupwm_pkg::OFF_CONTROL, 8'h1C);
      wait_rise(3);
      chk({16'h0, per_len}, 32'd32 << (2 * k));
      chk({16'h0, hi_len}, 32'd9 << (2 * k));
      if (k == 0) chk(n_ev, {16'h0, n_rise});
    end
    rd(cupwm_pkg::OFF_ACTIVE_DUTY, 8'h02);
    wr(cupwm_pkg::OFF_ACTIVE_DUTY, 8'h55);
    rd(cupwm_pkg::OFF_ACTIVE_DUTY, 8'h02);
    // New duty {05,01} = 21 held back until the period ends
    wr(cupwm_pkg::OFF_DUTY_BYTE, 8'h05);
    rd(cupwm_pkg::OFF_ACTIVE_DUTY, 8'h02);
    wait_rise(2);
    rd(cupwm_pkg::OFF_ACTIVE_DUTY, 8'h05);
    wait_rise(1);
    chk({16'h0, hi_len}, 32'd336);
    wr(cupwm_pkg::OFF_DUTY_BYTE, 8'h00);
    wr(cupwm_pkg::OFF_CONTROL, 8'h0C);
    repeat (1100) @(posedge pclk);
    n_hold = n_rise;
    repeat (1100) @(posedge pclk);
    chk({16'h0, n_rise, 15'h0, pin}, {16'h0, n_hold, 16'h0});
    // Duty 1023 beyond an 8-count period: pin never cleared
    wr(cupwm_pkg::OFF_DUTY_BYTE, 8'hFF);
    wr(cupwm_pkg::OFF_CONTROL, 8'h3C);
    repeat (1100) @(posedge pclk);
    n_hold = n_rise;
    repeat (1100) @(posedge pclk);
    chk({16'h0, n_rise, 15'h0, pin}, {16'h0, n_hold, 16'h1});
    rd(cupwm_pkg::OFF_STATUS, 8'h0F);
    wr(cupwm_pkg::OFF_CONTROL, 8'h00);
    repeat (2) @(posedge pclk);
    chk({31'h0, pin}, 32'h0);
    complete_run();
  end
endmodule // tb
